/* swd_pkg.sv */
// Package for the serial shift value to wiper decode block.
// Assumes a single 250 MHz clock domain and no register bus beyond the byte port.
`default_nettype none
package swd_pkg;
  // ==========================================
  // Widths and codes
  localparam int SWD_BYTE_W = 8;
  localparam int SWD_VAL_W = 7;
  localparam int SWD_TAP_W = 7;
  localparam logic [6:0] SWD_RESET_VALUE = 7'h40;
  localparam logic [6:0] SWD_ZERO_LIMIT = 7'h20;
  localparam logic [6:0] SWD_FULL_LIMIT = 7'h60;
  localparam logic [6:0] SWD_OFFSET = 7'h20;
  localparam logic [6:0] SWD_TAP_ZERO = 7'h00;
  localparam logic [6:0] SWD_TAP_FULL = 7'h40;
  localparam logic [7:0] SWD_CMD_VALUE = 8'h00;

  // Write request carried from the serial front end
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } swd_write_t;
endpackage
`default_nettype wire

/* swd_decode.sv */
// Serial shift value store and wiper tap decode.
// Assumes the serial front end delivers one-cycle strobes in the CLK_I domain:
// a write strobe at the falling edge of the last byte's acknowledge, and a
// read strobe when a data byte must be supplied.
//
// Contract
// R1: Store only low seven bits of byte.
// R2: Byte MSB discarded; stored value ignores it.
// R3: Wiper tap spans sixty-five positions 0-64.
// R4: Stored 20h or less gives tap 00h.
// R5: Stored 60h or more gives tap 40h.
// R6: Between, tap equals stored minus 20h.
// R7: Writes load value; reads return stored value.
// R8: Supply fault reset loads 40h, tap 20h.
// R9: Tap is unsigned binary ladder select.
// R10: Read byte MSB is always zero.
// R11: Latch on write acknowledge falling edge strobe.
// R12: Non-zero command neither writes nor reads.
// R13: Tap follows stored value without added latency.
`default_nettype none
module swd_decode
  import swd_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic WRITE_STROBE_I,
  input wire swd_write_t WRITE_I,
  input wire logic READ_STROBE_I,
  input wire logic [7:0] READ_CMD_I,
  output logic [7:0] READ_DATA_O,
  output logic READ_VALID_O,
  output logic [6:0] SERIAL_SHIFT_VALUE_O,
  output logic [6:0] WIPER_TAP_O
);

  // ==========================================
  // Stored value and tap
  logic [6:0] serial_shift_value;
  logic [6:0] wiper_tap;
  logic [7:0] read_data;
  logic read_valid;
  logic [6:0] next_serial_shift_value;
  logic [6:0] next_wiper_tap;
  logic [7:0] next_read_data;
  logic next_read_valid;
  logic [6:0] decoded;

  // Decode from a given stored value
  function automatic logic [6:0] tap_of(input logic [6:0] v);
    if (v <= SWD_ZERO_LIMIT) begin
      tap_of = SWD_TAP_ZERO; // R4
    end else if (v >= SWD_FULL_LIMIT) begin
      tap_of = SWD_TAP_FULL; // R5
    end else begin
      tap_of = v - SWD_OFFSET; // R6 R9
    end
  endfunction

  // ==========================================
  // Store group: value and tap land on one edge
  always_comb begin
    next_serial_shift_value = serial_shift_value;
    if (WRITE_STROBE_I && (WRITE_I.cmd == SWD_CMD_VALUE)) begin // R11 R12
      next_serial_shift_value = WRITE_I.data[6:0]; // R1 R2 R7
    end
    // Tap from the next value, so it never lags the store
    decoded = tap_of(next_serial_shift_value);
    next_wiper_tap = decoded; // R3 R13
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      serial_shift_value <= SWD_RESET_VALUE; // R8
      wiper_tap <= SWD_RESET_VALUE - SWD_OFFSET; // R8
    end else begin
      serial_shift_value <= next_serial_shift_value;
      wiper_tap <= next_wiper_tap;
    end
  end

  // ==========================================
  // Read group: old value wins a same-cycle write
  always_comb begin
    next_read_data = read_data;
    next_read_valid = 1'b0;
    if (READ_STROBE_I && (READ_CMD_I == SWD_CMD_VALUE)) begin // R12
      next_read_data = {1'b0, serial_shift_value}; // R7 R10
      next_read_valid = 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      read_data <= 8'h00;
      read_valid <= 1'b0;
    end else begin
      read_data <= next_read_data;
      read_valid <= next_read_valid;
    end
  end

  assign READ_DATA_O = read_data;
  assign READ_VALID_O = read_valid;
  assign SERIAL_SHIFT_VALUE_O = serial_shift_value;
  assign WIPER_TAP_O = wiper_tap;

  // ==========================================
  // Checks
  chk_tap_range: assert property (@(posedge CLK_I) disable iff (RESET_I) // R3
    wiper_tap <= 7'h40) else $error("tap above sixty-four");
  chk_zero_clamp: assert property (@(posedge CLK_I) disable iff (RESET_I) // R4
    serial_shift_value <= 7'h20 |-> wiper_tap == 7'h00) else $error("zero clamp wrong");
  chk_full_clamp: assert property (@(posedge CLK_I) disable iff (RESET_I) // R5
    serial_shift_value >= 7'h60 |-> wiper_tap == 7'h40) else $error("full clamp wrong");
  chk_mid_offset: assert property (@(posedge CLK_I) disable iff (RESET_I) // R6
    (serial_shift_value > 7'h20 && serial_shift_value < 7'h60)
      |-> wiper_tap == serial_shift_value - 7'h20) else $error("offset decode wrong");
  chk_write_load: assert property (@(posedge CLK_I) disable iff (RESET_I) // R1
    WRITE_STROBE_I && WRITE_I.cmd == 8'h00 |=> serial_shift_value == $past(WRITE_I.data[6:0]))
    else $error("write not loaded");
  chk_bad_cmd_hold: assert property (@(posedge CLK_I) disable iff (RESET_I) // R12
    WRITE_STROBE_I && WRITE_I.cmd != 8'h00 |=> $stable(serial_shift_value))
    else $error("bad command wrote");
  chk_read_msb: assert property (@(posedge CLK_I) disable iff (RESET_I) // R10
    READ_STROBE_I && READ_CMD_I == 8'h00
      |=> read_valid && read_data == {1'b0, $past(serial_shift_value)})
    else $error("read data wrong");
  chk_reset_mid: assert property (@(posedge CLK_I) // R8
    $past(RESET_I) |-> serial_shift_value == 7'h40 && wiper_tap == 7'h20)
    else $error("reset value wrong");
  chk_no_write_hold: assert property (@(posedge CLK_I) disable iff (RESET_I) // R11
    !WRITE_STROBE_I |=> $stable(serial_shift_value)) else $error("value changed unasked");
  chk_msb_ignored: assert property (@(posedge CLK_I) disable iff (RESET_I) // R2
    WRITE_STROBE_I && WRITE_I.cmd == 8'h00 && WRITE_I.data[7]
      |=> serial_shift_value == $past(WRITE_I.data[6:0])) else $error("top bit leaked");
  chk_write_tap: assert property (@(posedge CLK_I) disable iff (RESET_I) // R13
    WRITE_STROBE_I && WRITE_I.cmd == 8'h00 && WRITE_I.data[6:0] == 7'h40
      |=> wiper_tap == 7'h20) else $error("tap lags store");
  chk_floor_tap: assert property (@(posedge CLK_I) disable iff (RESET_I) // R4
    serial_shift_value == 7'h00 |-> wiper_tap == 7'h00) else $error("floor tap wrong");
  chk_ceiling_tap: assert property (@(posedge CLK_I) disable iff (RESET_I) // R5
    serial_shift_value == 7'h7f |-> wiper_tap == 7'h40) else $error("ceiling tap wrong");
  chk_read_refused: assert property (@(posedge CLK_I) disable iff (RESET_I) // R12
    READ_STROBE_I && READ_CMD_I != 8'h00 |=> !read_valid && $stable(read_data))
    else $error("bad command read");
  chk_read_idle: assert property (@(posedge CLK_I) disable iff (RESET_I) // R7
    !READ_STROBE_I |=> !read_valid && $stable(read_data)) else $error("read unasked");
  chk_read_top_bit: assert property (@(posedge CLK_I) disable iff (RESET_I) // R10
    read_data[7] == 1'b0) else $error("read top bit set");
  chk_reset_read: assert property (@(posedge CLK_I) // R8
    $past(RESET_I) |-> read_data == 8'h00 && !read_valid) else $error("read reset wrong");

  // ==========================================
  // Per-bit read echo
  for (genvar b = 0; b < SWD_VAL_W; b++) begin : g_read_bit
    chk_read_bit_echo: assert property (@(posedge CLK_I) disable iff (RESET_I) // R7
      READ_STROBE_I && READ_CMD_I == 8'h00
        |=> read_data[b] == $past(serial_shift_value[b])) else $error("read bit wrong");
  end

endmodule // swd_decode
`default_nettype wire

/* swd_master_model.sv */
// Serial front end model driving write and read strobes.
// Assumes one clock shared with the decode block.
`default_nettype none
module swd_master_model
  import swd_pkg::*;
(
  input wire logic clk_i,
  output logic wstb_o,
  output swd_write_t wr_o,
  output logic rstb_o,
  output logic [7:0] rcmd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wstb_o = 1'h0;
    wr_o = '0;
    rstb_o = 1'h0;
    rcmd_o = 8'h00;
  end
  task automatic put(input logic [7:0] c, input logic [7:0] d);
    @(posedge clk_i);
    wstb_o <= 1'h1;
    wr_o <= '{cmd: c, data: d};
    @(posedge clk_i);
    wstb_o <= 1'h0;
    wr_o <= ~wr_o;
  endtask
  task automatic get(input logic [7:0] c);
    @(posedge clk_i);
    rstb_o <= 1'h1;
    rcmd_o <= c;
    @(posedge clk_i);
    rstb_o <= 1'h0;
    rcmd_o <= ~rcmd_o;
  endtask
endmodule // swd_master_model
`default_nettype wire

/* swd_decode_tb.sv */
// Bench for the store and tap decode, via the master model.
`default_nettype none
module swd_decode_tb
  import swd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, ws, rs, rv;
  swd_write_t wr;
  logic [7:0] rc, rd;
  logic [6:0] v, t;
  int fail_count = 0, n_compared = 0, cyc = 0;
  logic [7:0] vec [10] = '{8'h00, 8'h20, 8'h21, 8'ha1, 8'h40, 8'hc0, 8'h5f, 8'h60, 8'hff, 8'hdf};
  swd_decode i_swd_decode(.CLK_I(clk), .RESET_I(rst), .WRITE_STROBE_I(ws), .WRITE_I(wr),
    .READ_STROBE_I(rs), .READ_CMD_I(rc), .READ_DATA_O(rd), .READ_VALID_O(rv),
    .SERIAL_SHIFT_VALUE_O(v), .WIPER_TAP_O(t));
  swd_master_model i_swd_master_model(.clk_i(clk), .wstb_o(ws), .wr_o(wr), .rstb_o(rs),
    .rcmd_o(rc));
  function automatic logic [7:0] tap_of(input logic [6:0] x);
    if (x <= 7'h20) return 8'h00;
    if (x >= 7'h60) return 8'h40;
    return {1'h0, x - 7'h20};
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic final_report();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    #1;
    chk({rv, v}, 8'h40);
    chk({1'h0, t}, 8'h20);
    chk(rd, 8'h00);
    $display("reset test done");
  endtask
  initial begin
    clk = 1'h0;
    rst = 1'h1;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    @(posedge clk);
    do_reset();
    foreach (vec[i]) begin
      i_swd_master_model.put(8'h00, vec[i]);
      #1;
      chk({1'h0, v}, {1'h0, vec[i][6:0]});
      chk({1'h0, t}, tap_of(vec[i][6:0]));
      i_swd_master_model.get(8'h00);
      #1;
      chk({rv, rd[6:0]}, {1'h1, vec[i][6:0]});
      chk({7'h00, rd[7]}, 8'h00);
    end
    $display("decode test done");
    i_swd_master_model.put(8'h01, 8'h10);
    i_swd_master_model.get(8'h80);
    #1;
    chk({rv, v}, 8'h5f);
    chk({1'h0, t}, 8'h3f);
    chk(rd, 8'h5f);
    $display("refusal test done");
    do_reset();
    final_report();
  end
endmodule // swd_decode_tb
`default_nettype wire
